// >>> seh_pkg.sv
// Purpose: shared constants of the eeprom serial session link
// Assumes: spi mode 0, msb first, one opcode byte then payload
// Notes:   times are in their own unit, counts derived from them

package seh_pkg;

  // ==========================================================
  // instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_WRITE         = 8'h02;

  // ==========================================================
  // status byte layout, fill values and address length
  localparam int         ST_BUSY_BIT  = 0;
  localparam int         ST_LATCH_BIT = 1;
  localparam logic [7:0] ST_RESET     = 8'h00;
  localparam logic [7:0] BUSY_FILL    = 8'hff;
  localparam logic [7:0] READ_FILL    = 8'hff;
  localparam logic [2:0] ADDR_BYTES   = 3'h2;

  // ==========================================================
  // timing and fifo depth and width
  localparam int CORE_MHZ    = 100;
  localparam int WC_TIME_US  = 5;
  localparam int WC_CYCLES   = WC_TIME_US * CORE_MHZ;
  localparam int SCK_HALF    = 4;
  localparam int FIFO_DEPTH  = 16;
  localparam int FIFO_WIDTH  = 9;

  // ==========================================================
  // decoded instruction kinds
  typedef enum logic [2:0] {
    K_NONE,
    K_IGNORE,
    K_WEN,
    K_WDIS,
    K_STATUS,
    K_WSTAT,
    K_READ,
    K_WRITE
  } seh_kind_t;

endpackage

// >>> seh_link_if.sv
// Purpose: the serial wires between host and eeprom
// Assumes: serial output idles high when nobody drives it
// Notes:   the resolved level stands in for a pull-up

`timescale 1ns/10ps

interface seh_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic hold_n;
  logic so_o;
  logic so_oe;
  logic so;

  assign so = so_oe ? so_o : 1'b1;

  modport dev
  (
    input  sck,
    input  cs_n,
    input  si,
    input  hold_n,
    output so_o,
    output so_oe
  );

  modport host
  (
    output sck,
    output cs_n,
    output si,
    output hold_n,
    input  so
  );
endinterface

// >>> seh_dev.sv
// Purpose: eeprom end of the serial session: framing, pause, latch,
//          self-timed write cycle and instruction filtering
// Assumes: link clock is sck; core_clk times the write cycle
// Notes:   array contents are outside; reads return a fill value

`timescale 1ns/10ps

module seh_dev #(
  parameter int WC_CYCLES = seh_pkg::WC_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  seh_link_if.dev   dv,
  output logic      write_busy,
  output logic      write_latch,
  output logic      write_start,
  output logic      write_done
);

  localparam int TW = $clog2(WC_CYCLES + 1);

  // ==========================================================
  // state types
  typedef struct packed {
    logic [2:0]         bit_cnt;
    logic [2:0]         byte_cnt;
    logic [7:0]         in_sh;
    logic [7:0]         out_sh;
    logic               talk;
    seh_pkg::seh_kind_t kind;
  } seh_frm_t;

  typedef struct packed {
    logic       ev_wen;
    logic       ev_wdis;
    logic       ev_arm;
    logic [1:0] busy_s;
    logic [1:0] latch_s;
  } seh_flg_t;

  typedef struct packed {
    logic so_bit;
    logic so_en;
  } seh_out_t;

  typedef struct packed {
    logic [1:0]    cs_s;
    logic          cs_prev;
    logic [1:0]    wen_s;
    logic [1:0]    wdis_s;
    logic [1:0]    arm_s;
    logic          latch;
    logic          busy;
    logic [TW-1:0] timer;
    logic          start;
    logic          done;
  } seh_core_t;

  // ==========================================================
  // opcode decode; a busy device honours only the status read
  function automatic seh_pkg::seh_kind_t decode(
    input logic [7:0] op,
    input logic       busy
  );
    seh_pkg::seh_kind_t k;
    k = seh_pkg::K_IGNORE;
    case (op)
      seh_pkg::OP_READ_STATUS:   k = seh_pkg::K_STATUS;
      seh_pkg::OP_WRITE_ENABLE:  k = seh_pkg::K_WEN;
      seh_pkg::OP_WRITE_DISABLE: k = seh_pkg::K_WDIS;
      seh_pkg::OP_WRITE_STATUS:  k = seh_pkg::K_WSTAT;
      seh_pkg::OP_READ:          k = seh_pkg::K_READ;
      seh_pkg::OP_WRITE:         k = seh_pkg::K_WRITE;
      default:                   k = seh_pkg::K_IGNORE;
    endcase
    if (busy && k != seh_pkg::K_STATUS)
    begin
      k = seh_pkg::K_IGNORE;
    end
    return k;
  endfunction

  seh_frm_t  frm_q, frm_d;
  seh_flg_t  flg_q, flg_d;
  seh_out_t  out_q, out_d;
  seh_core_t cor_q, cor_d;
  logic      frame_rst_n;
  logic      accept;
  logic      last_bit;
  logic [7:0] byte_in;
  logic [7:0] status;
  seh_pkg::seh_kind_t op_kind;

  // frame logic is held idle while deselected, so every instruction
  // starts from a clean count once select falls
  assign frame_rst_n = arst_n & ~dv.cs_n;

  // ==========================================================
  // link side, rising edge
  always_comb
  begin
    accept   = dv.hold_n;
    last_bit = (frm_q.bit_cnt == 3'h7);
    byte_in  = {frm_q.in_sh[6:0], dv.si};
    op_kind  = decode(byte_in, flg_q.busy_s[1]);
    status   = seh_pkg::ST_RESET;
    status[seh_pkg::ST_BUSY_BIT]  = flg_q.busy_s[1];
    status[seh_pkg::ST_LATCH_BIT] = flg_q.latch_s[1];
    frm_d = frm_q;
    flg_d = flg_q;
    flg_d.busy_s  = {flg_q.busy_s[0], cor_q.busy};
    flg_d.latch_s = {flg_q.latch_s[0], cor_q.latch};
    if (accept)
    begin
      frm_d.bit_cnt = frm_q.bit_cnt + 3'h1;
      frm_d.in_sh   = byte_in;
      frm_d.out_sh  = {frm_q.out_sh[6:0], 1'b0};
      // flags say the last edge closed a complete instruction;
      // any further bit spoils them, so counts must be exact, but a write re-arms at the end of each later data byte
      flg_d.ev_wen  = 1'b0;
      flg_d.ev_wdis = 1'b0;
      flg_d.ev_arm  = 1'b0;
      if (last_bit)
      begin
        if (frm_q.byte_cnt != 3'h7)
        begin
          frm_d.byte_cnt = frm_q.byte_cnt + 3'h1;
        end
        if (frm_q.byte_cnt == 3'h0)
        begin
          frm_d.kind    = op_kind;
          flg_d.ev_wen  = (op_kind == seh_pkg::K_WEN);
          flg_d.ev_wdis = (op_kind == seh_pkg::K_WDIS);
        end
        case (frm_d.kind)
          seh_pkg::K_STATUS:
          begin
            frm_d.talk   = 1'b1;
            frm_d.out_sh = flg_q.busy_s[1] ? seh_pkg::BUSY_FILL
                                           : status;
          end
          seh_pkg::K_READ:
          begin
            if (frm_q.byte_cnt >= seh_pkg::ADDR_BYTES)
            begin
              frm_d.talk   = 1'b1;
              frm_d.out_sh = seh_pkg::READ_FILL;
            end
          end
          seh_pkg::K_WSTAT:
          begin
            flg_d.ev_arm = (frm_q.byte_cnt == 3'h1);
          end
          seh_pkg::K_WRITE:
          begin
            flg_d.ev_arm = (frm_q.byte_cnt > seh_pkg::ADDR_BYTES);
          end
          default:
          begin
            frm_d.talk = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge dv.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      frm_q <= '{kind: seh_pkg::K_NONE, default: '0};
    end
    else
    begin
      frm_q <= frm_d;
    end
  end

  // flags must survive the select rise, so only power-on clears them
  always_ff @(posedge dv.sck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flg_q <= '0;
    end
    else
    begin
      flg_q <= flg_d;
    end
  end

  // ==========================================================
  // link side, falling edge drives the serial output
  always_comb
  begin
    out_d = out_q;
    if (dv.hold_n)
    begin
      out_d.so_bit = frm_q.out_sh[7];
      out_d.so_en  = frm_q.talk;
    end
  end

  always_ff @(negedge dv.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      out_q <= '0;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  assign dv.so_o  = out_q.so_bit;
  assign dv.so_oe = out_q.so_en & dv.hold_n & ~dv.cs_n;

  // ==========================================================
  // core side: select rise commits the instruction
  always_comb
  begin
    cor_d         = cor_q;
    cor_d.cs_s    = {cor_q.cs_s[0], dv.cs_n};
    cor_d.cs_prev = cor_q.cs_s[1];
    cor_d.wen_s   = {cor_q.wen_s[0], flg_q.ev_wen};
    cor_d.wdis_s  = {cor_q.wdis_s[0], flg_q.ev_wdis};
    cor_d.arm_s   = {cor_q.arm_s[0], flg_q.ev_arm};
    cor_d.start   = 1'b0;
    cor_d.done    = 1'b0;
    if (cor_q.busy)
    begin
      cor_d.timer = cor_q.timer - TW'(1);
      if (cor_q.timer == '0)
      begin
        cor_d.busy  = 1'b0;
        cor_d.latch = 1'b0;
        cor_d.done  = 1'b1;
      end
    end
    else if (cor_q.cs_s[1] && !cor_q.cs_prev)
    begin
      if (cor_q.wen_s[1])
      begin
        cor_d.latch = 1'b1;
      end
      if (cor_q.wdis_s[1])
      begin
        cor_d.latch = 1'b0;
      end
      // without the latch the write is silently dropped
      if (cor_q.arm_s[1] && cor_q.latch)
      begin
        cor_d.busy  = 1'b1;
        cor_d.start = 1'b1;
        cor_d.timer = TW'(WC_CYCLES - 1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cor_q <= '{cs_s: 2'h3, cs_prev: 1'b1, default: '0};
    end
    else
    begin
      cor_q <= cor_d;
    end
  end

  assign write_busy  = cor_q.busy;
  assign write_latch = cor_q.latch;
  assign write_start = cor_q.start;
  assign write_done  = cor_q.done;

endmodule

// >>> seh_host.sv
// Purpose: host end: byte queue, clock divider, select and pause
// Assumes: each queued word is {last, byte}; last ends the frame
// Notes:   serial clock is derived from core_clk, so one domain

`timescale 1ns/10ps

// ============================================================
// synchronous fifo
module seh_fifo #(
  parameter int W = seh_pkg::FIFO_WIDTH,
  parameter int D = seh_pkg::FIFO_DEPTH
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         push;
  logic         pop;

  assign in_ready  = (wp_q - rp_q) != (AW+1)'(D);
  assign out_valid = wp_q != rp_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rp_q[AW-1:0]];

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
    end
  end
endmodule

// ============================================================
// serial engine
module seh_host #(
  parameter int HALF = seh_pkg::SCK_HALF
) (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  seh_link_if.host        hl,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  input  wire logic       pause_req,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            frame_active
);
  typedef enum logic [2:0] {
    S_IDLE, S_LOW, S_HIGH, S_PAUSE, S_NEXT, S_END, S_GAP
  } seh_st_t;

  typedef struct packed {
    seh_st_t    st;
    logic [7:0] cnt;
    logic [7:0] sh;
    logic [2:0] bits;
    logic       last;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic [1:0] so_s;
    logic       sck;
    logic       cs_n;
    logic       hold_n;
    logic       mosi;
  } seh_hst_t;

  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

  seh_hst_t   s_q, s_d;
  logic       f_valid;
  logic       f_ready;
  logic [8:0] f_data;

  seh_fifo #(.W(seh_pkg::FIFO_WIDTH), .D(seh_pkg::FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   ({tx_last, tx_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  assign f_ready = (s_q.st == S_IDLE) || (s_q.st == S_NEXT);

  always_comb
  begin
    s_d          = s_q;
    s_d.so_s     = {s_q.so_s[0], hl.so};
    s_d.rx_valid = 1'b0;
    s_d.cnt      = (s_q.cnt == 8'h00) ? 8'h00 : s_q.cnt - 8'h01;
    case (s_q.st)
      S_IDLE, S_NEXT:
      begin
        if (f_valid)
        begin
          s_d.sh   = f_data[7:0];
          s_d.last = f_data[8];
          s_d.mosi = f_data[7];
          s_d.bits = 3'h0;
          s_d.cnt  = HALF_M1;
          s_d.cs_n = 1'b0;
          s_d.st   = S_LOW;
        end
      end
      S_LOW:
      begin
        if (s_q.cnt == 8'h00)
        begin
          if (pause_req)
          begin
            s_d.hold_n = 1'b0;
            s_d.st     = S_PAUSE;
          end
          else
          begin
            s_d.sck = 1'b1;
            s_d.cnt = HALF_M1;
            s_d.st  = S_HIGH;
          end
        end
      end
      S_PAUSE:
      begin
        // select stays low and the clock stays low throughout
        if (!pause_req)
        begin
          s_d.hold_n = 1'b1;
          s_d.cnt    = HALF_M1;
          s_d.st     = S_LOW;
        end
      end
      S_HIGH:
      begin
        if (s_q.cnt == 8'h00)
        begin
          s_d.sck   = 1'b0;
          s_d.rx_sh = {s_q.rx_sh[6:0], s_q.so_s[1]};
          s_d.sh    = {s_q.sh[6:0], 1'b0};
          s_d.mosi  = s_q.sh[6];
          s_d.bits  = s_q.bits + 3'h1;
          s_d.cnt   = HALF_M1;
          s_d.st    = S_LOW;
          if (s_q.bits == 3'h7)
          begin
            s_d.rx_data  = {s_q.rx_sh[6:0], s_q.so_s[1]};
            s_d.rx_valid = 1'b1;
            s_d.st       = s_q.last ? S_END : S_NEXT;
          end
        end
      end
      S_END:
      begin
        if (s_q.cnt == 8'h00)
        begin
          s_d.cs_n = 1'b1;
          s_d.cnt  = HALF_M1;
          s_d.st   = S_GAP;
        end
      end
      S_GAP:
      begin
        if (s_q.cnt == 8'h00)
        begin
          s_d.st = S_IDLE;
        end
      end
      default:
      begin
        s_d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '{st: S_IDLE, cs_n: 1'b1, hold_n: 1'b1, so_s: 2'h3,
               default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign hl.sck       = s_q.sck;
  assign hl.cs_n      = s_q.cs_n;
  assign hl.si        = s_q.mosi;
  assign hl.hold_n    = s_q.hold_n;
  assign rx_valid     = s_q.rx_valid;
  assign rx_data      = s_q.rx_data;
  assign frame_active = ~s_q.cs_n;

endmodule

// >>> seh_link_assertions.sv
// Purpose: concurrent checks on the serial link and write cycle
// Assumes: sck is made from core_clk, so one sampling clock serves
// Notes:   WCYC must match the device's write cycle parameter

`timescale 1ns/10ps

module seh_link_assertions #(
  parameter int WCYC = 20
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic write_busy,
  input wire logic write_latch,
  input wire logic write_start,
  input wire logic write_done
);
  // ==========================================================
  // busy length counter
  int cnt_q;
  int cnt_d;

  always_comb
    cnt_d = write_busy ? cnt_q + 1 : 0;

  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      cnt_q <= 0;
    else
      cnt_q <= cnt_d;

  // ==========================================================
  // properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  property p_hold_fall;
    $fell(hold_n) |-> !sck;
  endproperty
  a_hold_fall: assert property (p_hold_fall)
    else $error("pause began with clock high");

  property p_hold_rise;
    $rose(hold_n) |-> !sck;
  endproperty
  a_hold_rise: assert property (p_hold_rise)
    else $error("pause ended with clock high");

  property p_hold_sel;
    !hold_n |-> !cs_n && !sck;
  endproperty
  a_hold_sel: assert property (p_hold_sel)
    else $error("select or clock moved during pause");

  property p_hold_float;
    !hold_n |-> !so_oe;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("output driven during pause");

  // the past sample covers the frame reset itself, not only the
  // gating of the enable by select
  property p_idle_float;
    (cs_n || $past(cs_n)) |-> !so_oe;
  endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("output driven while deselected");

  property p_len;
    $fell(write_busy) |-> cnt_q == WCYC;
  endproperty
  a_len: assert property (p_len)
    else $error("write cycle length wrong");

  property p_start_sel;
    write_start |-> cs_n || $past(cs_n);
  endproperty
  a_start_sel: assert property (p_start_sel)
    else $error("write began without select rise");

  property p_latch_sel;
    $rose(write_latch) |-> (cs_n || $past(cs_n)) && !write_busy;
  endproperty
  a_latch_sel: assert property (p_latch_sel)
    else $error("latch set outside select rise or while busy");

  property p_no_restart;
    write_start |-> !$past(write_busy);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("write began during write cycle");

  property p_done_clear;
    write_done |-> ##[0:3] !write_latch;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("latch not cleared after write");

  property p_edges;
    ($changed(so_o) || $changed(si)) |-> !sck;
  endproperty
  a_edges: assert property (p_edges)
    else $error("data moved with clock high");

  c_start: cover property (write_start);
  c_pause: cover property (!hold_n);
  c_drive: cover property (so_oe);
endmodule

// >>> testbench.sv
// Purpose: host and device joined over the link, against a model
// Assumes: one frame at a time; write cycle far longer than a frame
// Notes:   undriven output reads as ones through the pull-up

`timescale 1ns/10ps

module testbench;
  // long write cycle so several frames fit inside one
  localparam int WCYC = 800;
  logic        core_clk;
  logic        arst_n;
  logic        tx_valid;
  logic        tx_ready;
  logic [7:0]  tx_data;
  logic        tx_last;
  logic        pause_req;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        frame_active;
  logic        write_busy;
  logic        write_latch;
  logic        write_start;
  logic        write_done;
  int          errors;
  int          checks;
  int          cyc;
  int          starts;
  int          dones;
  int          m_starts;
  int          busy_until;
  int          refused;
  logic        m_latch;
  logic [31:0] rng;
  logic [7:0]  exp_q[$];
  logic [7:0]  fq[$];

  // ==========================================================
  // design
  seh_link_if u_seh_link_if ();

  seh_dev #(.WC_CYCLES(WCYC)) u_seh_dev (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .dv          (u_seh_link_if),
    .write_busy  (write_busy),
    .write_latch (write_latch),
    .write_start (write_start),
    .write_done  (write_done)
  );

  seh_host u_seh_host (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .hl           (u_seh_link_if),
    .tx_valid     (tx_valid),
    .tx_ready     (tx_ready),
    .tx_data      (tx_data),
    .tx_last      (tx_last),
    .pause_req    (pause_req),
    .rx_valid     (rx_valid),
    .rx_data      (rx_data),
    .frame_active (frame_active)
  );

  seh_link_assertions #(.WCYC(WCYC)) u_seh_link_assertions (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .sck         (u_seh_link_if.sck),
    .cs_n        (u_seh_link_if.cs_n),
    .si          (u_seh_link_if.si),
    .hold_n      (u_seh_link_if.hold_n),
    .so_o        (u_seh_link_if.so_o),
    .so_oe       (u_seh_link_if.so_oe),
    .write_busy  (write_busy),
    .write_latch (write_latch),
    .write_start (write_start),
    .write_done  (write_done)
  );

  // ==========================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [7:0] rb();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction

  // sends fq as one frame, optionally paused, then updates the model
  task automatic frame(input bit pz);
    logic [7:0] op;
    logic [7:0] st;
    bit         busy;
    int         n;
    int         k;
    op = fq[0];
    n = fq.size();
    if (busy_until != 0 && cyc >= busy_until)
    begin
      m_latch = 1'b0;
      busy_until = 0;
    end
    busy = busy_until != 0;
    st = seh_pkg::ST_RESET;
    st[seh_pkg::ST_LATCH_BIT] = m_latch;
    exp_q.push_back(8'hff);
    for (k = 1; k < n; k++)
      if (op != seh_pkg::OP_READ_STATUS)
        exp_q.push_back(k > 2 ? seh_pkg::READ_FILL : 8'hff);
      else
        exp_q.push_back(busy ? seh_pkg::BUSY_FILL : st);
    for (k = 0; k < n; k++)
    begin
      tx_valid = 1'b1;
      tx_data = fq[k];
      tx_last = (k == n - 1);
      @(negedge core_clk);
      while (tx_ready !== 1'b1)
      begin
        refused++;
        @(negedge core_clk);
      end
      @(posedge core_clk);
      #1;
    end
    tx_valid = 1'b0;
    if (pz)
    begin
      repeat (60) @(posedge core_clk);
      #1 pause_req = 1'b1;
      repeat (40) @(posedge core_clk);
      #1 pause_req = 1'b0;
    end
    repeat (4) @(posedge core_clk);
    while (frame_active !== 1'b0)
      @(posedge core_clk);
    repeat (6) @(posedge core_clk);
    if (!busy)
    begin
      if (op == seh_pkg::OP_WRITE_ENABLE && n == 1)
        m_latch = 1'b1;
      if (op == seh_pkg::OP_WRITE_DISABLE && n == 1)
        m_latch = 1'b0;
      if (m_latch && ((op == seh_pkg::OP_WRITE && n >= 4) ||
          (op == seh_pkg::OP_WRITE_STATUS && n == 2)))
      begin
        m_starts++;
        busy_until = cyc + WCYC;
      end
    end
    #1;
    check({7'h00, write_latch}, {7'h00, m_latch});
    check({7'h00, write_busy}, {7'h00, busy_until != 0});
    check(8'(starts), 8'(m_starts));
    check(8'(dones), 8'(m_starts - int'(busy_until != 0)));
  endtask

  // ==========================================================
  // clock, monitors, timeout
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // sampled mid-cycle, where registered outputs have settled
  always @(negedge core_clk)
  begin
    cyc++;
    if (write_start === 1'b1)
      starts++;
    if (write_done === 1'b1)
      dones++;
    if (rx_valid === 1'b1)
      check(rx_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    if (cyc == 20000)
    begin
      errors++;
      close_out();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    rng = 32'h0000_45cc;
    arst_n = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    tx_last = 1'b0;
    pause_req = 1'b0;
    m_latch = 1'b0;
    repeat (20) @(posedge core_clk);
    #1 arst_n = 1'b1;
    fq = '{seh_pkg::OP_READ_STATUS, 8'h00};
    frame(0);
    fq = '{seh_pkg::OP_WRITE, rb(), rb(), rb()};
    frame(0);
    repeat (4)
    begin
      fq = '{rb() | 8'h80, rb()};
      frame(0);
    end
    fq = '{seh_pkg::OP_WRITE_ENABLE, 8'h00};
    frame(0);
    fq = '{seh_pkg::OP_WRITE_ENABLE};
    frame(0);
    fq = '{seh_pkg::OP_READ_STATUS, 8'h00};
    frame(1);
    fq = '{seh_pkg::OP_WRITE_DISABLE};
    frame(0);
    fq = '{seh_pkg::OP_WRITE_ENABLE};
    frame(0);
    fq = '{seh_pkg::OP_WRITE, rb(), rb(), rb(), rb()};
    frame(0);
    fq = '{seh_pkg::OP_READ_STATUS, 8'h00};
    frame(0);
    fq = '{seh_pkg::OP_WRITE_ENABLE};
    frame(0);
    fq = '{seh_pkg::OP_WRITE, rb(), rb(), rb()};
    frame(0);
    repeat (WCYC) @(posedge core_clk);
    #1;
    fq = '{seh_pkg::OP_READ_STATUS, 8'h00};
    frame(0);
    fq = '{seh_pkg::OP_WRITE_ENABLE};
    frame(0);
    fq = '{seh_pkg::OP_WRITE_STATUS, rb()};
    frame(0);
    repeat (WCYC) @(posedge core_clk);
    #1;
    fq = '{seh_pkg::OP_READ};
    repeat (19) fq.push_back(rb());
    frame(0);
    check({7'h00, refused > 0}, 8'h01);
    close_out();
  end
endmodule
